// file: ddrb_pkg.sv
// Package: constants, types and address decode for the duty byte bank
package ddrb_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int AXI_DATA_W      = 32;
    localparam int AXI_ADDR_W      = 12;
    localparam int BYTE_ADDR_SHIFT = 2;
    localparam int IDX_W           = AXI_ADDR_W - BYTE_ADDR_SHIFT;
    localparam int DUTY_BYTE_W     = 8;
    localparam int DUTY_WORD_W     = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is index times four
    localparam logic [IDX_W-1:0] IDX_DUTY_BYTE_SINK11_OR_SINK5_HIGH  = 10'h20b;
    localparam logic [IDX_W-1:0] IDX_DUTY_BYTE_SINK12_OR_SINK6_LOW   = 10'h20c;
    localparam logic [IDX_W-1:0] IDX_DUTY_BYTE_SINK13_OR_SINK6_HIGH  = 10'h20d;
    localparam logic [IDX_W-1:0] IDX_DUTY_BYTE_SINK14_OR_SINK7_LOW   = 10'h20e;
    localparam logic [IDX_W-1:0] IDX_DUTY_BYTE_SINK15_OR_SINK7_HIGH  = 10'h20f;
    localparam logic [IDX_W-1:0] IDX_DUTY_BYTE_SINK16_OR_SINK8_LOW   = 10'h210;
    localparam logic [IDX_W-1:0] IDX_DUTY_BYTE_SINK17_OR_SINK8_HIGH  = 10'h211;
    localparam logic [IDX_W-1:0] IDX_DUTY_SINK9_LOW                  = 10'h212;
    localparam logic [IDX_W-1:0] IDX_DUTY_SINK9_HIGH                 = 10'h213;
    localparam logic [IDX_W-1:0] IDX_DUTY_SINK10_LOW                 = 10'h214;
    localparam logic [IDX_W-1:0] IDX_DUTY_SINK10_HIGH                = 10'h215;
    localparam logic [IDX_W-1:0] IDX_DUTY_SINK11_LOW                 = 10'h216;
    localparam logic [IDX_W-1:0] IDX_DUTY_SINK11_HIGH                = 10'h217;
    localparam logic [IDX_W-1:0] IDX_DUTY_SINK12_LOW                 = 10'h218;

    localparam logic [IDX_W-1:0] IDX_FIRST = IDX_DUTY_BYTE_SINK11_OR_SINK5_HIGH;
    localparam logic [IDX_W-1:0] IDX_LAST  = IDX_DUTY_SINK12_LOW;

    ////////////////////////////////////////////////////////////////////////
    // Storage and sink layout
    localparam int NUM_DUTY_BYTES = 14;
    localparam int MEM_IDX_W      = 4;
    localparam logic [DUTY_BYTE_W-1:0] DUTY_RESET = 8'h00;
    localparam int NUM_SINK8      = 7;
    localparam int NUM_SINK16     = 6;

    // Result of decoding one bus address
    typedef struct packed {
        logic                 hit;
        logic [MEM_IDX_W-1:0] slot;
    } ddrb_decode_t;

    // Maps a byte address to a storage slot; misaligned or unmapped misses
    function automatic ddrb_decode_t ddrb_decode(
        input logic [AXI_ADDR_W-1:0] addr
    );
        ddrb_decode_t      d;
        logic [IDX_W-1:0]  idx;
        idx    = addr[AXI_ADDR_W-1:BYTE_ADDR_SHIFT];
        d.hit  = (addr[BYTE_ADDR_SHIFT-1:0] == 2'h0) &&
                 (idx >= IDX_FIRST) && (idx <= IDX_LAST);
        d.slot = d.hit ? MEM_IDX_W'(idx - IDX_FIRST) : 4'h0;
        return d;
    endfunction : ddrb_decode

endpackage : ddrb_pkg

// file: ddrb_byte_mem.sv
// Small byte store with one write port, a registered read port, all cells out
module ddrb_byte_mem
    import ddrb_pkg::*;
#(
    parameter int DEPTH  = NUM_DUTY_BYTES,
    parameter int WIDTH  = DUTY_BYTE_W,
    parameter int SLOT_W = MEM_IDX_W
) (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         wrEn,
    input  wire logic [SLOT_W-1:0]            wrSlot,
    input  wire logic [WIDTH-1:0]             wrData,
    input  wire logic                         rdEn,
    input  wire logic [SLOT_W-1:0]            rdSlot,
    output logic      [WIDTH-1:0]             rdData,
    output logic      [DEPTH-1:0][WIDTH-1:0]  cells
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] cells;
        logic [WIDTH-1:0]            rdData;
    } ddrb_mem_state_t;

    localparam logic [DEPTH-1:0][WIDTH-1:0] RESET_CELLS =
        {DEPTH{WIDTH'(DUTY_RESET)}};

    ddrb_mem_state_t state;
    ddrb_mem_state_t next_state;

    // Slots beyond the depth are dropped rather than aliased
    always_comb begin
        next_state = state;
        if (wrEn && (wrSlot < SLOT_W'(DEPTH))) begin
            next_state.cells[wrSlot] = wrData;
        end
        if (rdEn) begin
            next_state.rdData = (rdSlot < SLOT_W'(DEPTH)) ?
                                state.cells[rdSlot] : '0;
        end
    end

    // Every cell comes up at the duty reset value
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '{cells: RESET_CELLS, rdData: '0};
        end else begin
            state <= next_state;
        end
    end

    assign rdData = state.rdData;
    assign cells  = state.cells;

endmodule : ddrb_byte_mem

// file: ddrb_duty_bank.sv
// Duty byte bank: AXI4-Lite slave, byte storage and per-sink duty outputs
//
// Operation
// - 0x20C: sink 12 duty, or sink 6 low
// - 0x20D: sink 13 duty, or sink 6 high
// - 0x20E: sink 14 duty, or sink 7 low
// - 0x20F: sink 15 duty, or sink 7 high
// - 0x210: sink 16 duty, or sink 8 low
// - 0x211: sink 17 duty, or sink 8 high
// - 0x212/0x213: sink 9 sixteen-bit halves
// - 0x214/0x215: sink 10 sixteen-bit halves
// - 0x216/0x217: sink 11 sixteen-bit halves
// - All bytes read/write, zero after reset
// - 0x20B: sink 11 duty, or sink 5 high
module ddrb_duty_bank
    import ddrb_pkg::*;
(
    input  wire logic                                   clk,
    input  wire logic                                   rst_b,
    // Write address channel
    input  wire logic [AXI_ADDR_W-1:0]                  awaddr,
    input  wire logic [2:0]                             awprot,
    input  wire logic                                   awvalid,
    output logic                                        awready,
    // Write data channel
    input  wire logic [AXI_DATA_W-1:0]                  wdata,
    input  wire logic [AXI_DATA_W/8-1:0]                wstrb,
    input  wire logic                                   wvalid,
    output logic                                        wready,
    // Write response channel
    output logic      [1:0]                             bresp,
    output logic                                        bvalid,
    input  wire logic                                   bready,
    // Read address channel
    input  wire logic [AXI_ADDR_W-1:0]                  araddr,
    input  wire logic [2:0]                             arprot,
    input  wire logic                                   arvalid,
    output logic                                        arready,
    // Read data channel
    output logic      [AXI_DATA_W-1:0]                  rdata,
    output logic      [1:0]                             rresp,
    output logic                                        rvalid,
    input  wire logic                                   rready,
    // Duty-width setting from the core, same clock
    input  wire logic                                   dutyWide16,
    // Duty values toward the PWM generators
    output logic      [NUM_SINK8-1:0][DUTY_BYTE_W-1:0]  sinkDuty8,
    output logic      [NUM_SINK16-1:0][DUTY_WORD_W-1:0] sinkDuty16,
    output logic      [DUTY_BYTE_W-1:0]                 sink5DutyHigh,
    output logic      [DUTY_BYTE_W-1:0]                 sink12DutyLow
);

    ////////////////////////////////////////////////////////////////////////
    // State of the bus slave and the duty output registers
    typedef struct packed {
        logic                                   awHeld;
        logic [AXI_ADDR_W-1:0]                  awAddrHeld;
        logic                                   wHeld;
        logic [DUTY_BYTE_W-1:0]                 wDataHeld;
        logic                                   wLaneHeld;
        logic                                   bvalid;
        logic [1:0]                             bresp;
        logic                                   rdPend;
        logic                                   rdHit;
        logic                                   rvalid;
        logic [1:0]                             rresp;
        logic [AXI_DATA_W-1:0]                  rdata;
        logic [NUM_SINK8-1:0][DUTY_BYTE_W-1:0]  duty8;
        logic [NUM_SINK16-1:0][DUTY_WORD_W-1:0] duty16;
        logic [DUTY_BYTE_W-1:0]                 sink5High;
        logic [DUTY_BYTE_W-1:0]                 sink12Low;
    } ddrb_state_t;

    ddrb_state_t state;
    ddrb_state_t next_state;

    // Combinational helpers
    logic                                       awFire;
    logic                                       wFire;
    logic                                       arFire;
    logic                                       haveAw;
    logic                                       haveW;
    logic                                       doWrite;
    logic [AXI_ADDR_W-1:0]                      curAwAddr;
    logic [DUTY_BYTE_W-1:0]                     curWData;
    logic                                       curWLane;
    ddrb_decode_t                               wrDec;
    ddrb_decode_t                               rdDec;
    logic                                       memWrEn;
    logic                                       memRdEn;
    logic [DUTY_BYTE_W-1:0]                     memRdData;
    logic [NUM_DUTY_BYTES-1:0][DUTY_BYTE_W-1:0] cells;

    ////////////////////////////////////////////////////////////////////////
    // Byte storage; read data arrive one cycle after the slot is given
    ddrb_byte_mem #(
        .DEPTH  (NUM_DUTY_BYTES),
        .WIDTH  (DUTY_BYTE_W),
        .SLOT_W (MEM_IDX_W)
    ) u_mem (
        .clk    (clk),
        .rst_b  (rst_b),
        .wrEn   (memWrEn),
        .wrSlot (wrDec.slot),
        .wrData (curWData),
        .rdEn   (memRdEn),
        .rdSlot (rdDec.slot),
        .rdData (memRdData),
        .cells  (cells)
    );

    ////////////////////////////////////////////////////////////////////////
    // Handshakes; a pending response blocks new writes, one read at a time
    assign awready = !state.awHeld && !state.bvalid;
    assign wready  = !state.wHeld && !state.bvalid;
    assign arready = !state.rdPend && !state.rvalid;
    assign awFire  = awvalid && awready;
    assign wFire   = wvalid && wready;
    assign arFire  = arvalid && arready;

    // Address and data may come in either order; use held or live copies
    assign haveAw    = state.awHeld || awFire;
    assign haveW     = state.wHeld || wFire;
    assign doWrite   = haveAw && haveW;
    assign curAwAddr = state.awHeld ? state.awAddrHeld : awaddr;
    assign curWData  = state.wHeld ? state.wDataHeld : wdata[DUTY_BYTE_W-1:0];
    assign curWLane  = state.wHeld ? state.wLaneHeld : wstrb[0];
    assign wrDec     = ddrb_decode(curAwAddr);
    assign rdDec     = ddrb_decode(araddr);

    // Only byte lane 0 carries duty data; other lanes are ignored
    assign memWrEn = doWrite && wrDec.hit && curWLane;
    assign memRdEn = arFire && rdDec.hit;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_state = state;

        // Write channel bookkeeping
        next_state.awHeld = haveAw && !doWrite;
        next_state.wHeld  = haveW && !doWrite;
        if (awFire) begin
            next_state.awAddrHeld = awaddr;
        end
        if (wFire) begin
            next_state.wDataHeld = wdata[DUTY_BYTE_W-1:0];
            next_state.wLaneHeld = wstrb[0];
        end

        // Write response; an unmapped address answers with an error
        if (doWrite) begin
            next_state.bvalid = 1'b1;
            next_state.bresp  = wrDec.hit ? RESP_OKAY : RESP_SLVERR;
        end else if (state.bvalid && bready) begin
            next_state.bvalid = 1'b0;
        end

        // Read: one wait cycle for the storage, then the answer
        if (arFire) begin
            next_state.rdPend = 1'b1;
            next_state.rdHit  = rdDec.hit;
        end
        if (state.rdPend) begin
            next_state.rdPend = 1'b0;
            next_state.rvalid = 1'b1;
            next_state.rresp  = state.rdHit ? RESP_OKAY : RESP_SLVERR;
            // Upper bits read as zero
            next_state.rdata  = state.rdHit ?
                                AXI_DATA_W'(memRdData) : '0;
        end else if (state.rvalid && rready) begin
            next_state.rvalid = 1'b0;
        end

        // Duty outputs; the unused width reads zero so a stale value
        // cannot reach a generator after the width setting flips
        next_state.duty8     = '0;
        next_state.duty16    = '0;
        next_state.sink5High = '0;
        next_state.sink12Low = '0;
        if (!dutyWide16) begin
            next_state.duty8[0] = cells[0];
            next_state.duty8[1] = cells[1];
            next_state.duty8[2] = cells[2];
            next_state.duty8[3] = cells[3];
            next_state.duty8[4] = cells[4];
            next_state.duty8[5] = cells[5];
            next_state.duty8[6] = cells[6];
        end else begin
            next_state.sink5High = cells[0];
            // Shared bytes: low half from the even address
            next_state.duty16[0][7:0]  = cells[1];
            next_state.duty16[0][15:8] = cells[2];
            next_state.duty16[1][7:0]  = cells[3];
            next_state.duty16[1][15:8] = cells[4];
            next_state.duty16[2][7:0]  = cells[5];
            next_state.duty16[2][15:8] = cells[6];
            next_state.duty16[3] = {cells[8], cells[7]};
            next_state.duty16[4] = {cells[10], cells[9]};
            next_state.duty16[5] = {cells[12], cells[11]};
            next_state.sink12Low = cells[13];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign bvalid        = state.bvalid;
    assign bresp         = state.bresp;
    assign rvalid        = state.rvalid;
    assign rresp         = state.rresp;
    assign rdata         = state.rdata;
    assign sinkDuty8     = state.duty8;
    assign sinkDuty16    = state.duty16;
    assign sink5DutyHigh = state.sink5High;
    assign sink12DutyLow = state.sink12Low;

endmodule : ddrb_duty_bank

// file: ddrb_duty_bank_checker.sv
// Concurrent checks on the bus handshake and duty outputs of the byte bank
module ddrb_duty_bank_checker
    import ddrb_pkg::*;
(
    input wire logic                                   clk,
    input wire logic                                   rst_b,
    input wire logic                                   awvalid,
    input wire logic                                   awready,
    input wire logic                                   wvalid,
    input wire logic                                   wready,
    input wire logic [1:0]                             bresp,
    input wire logic                                   bvalid,
    input wire logic                                   bready,
    input wire logic                                   arvalid,
    input wire logic                                   arready,
    input wire logic [AXI_DATA_W-1:0]                  rdata,
    input wire logic [1:0]                             rresp,
    input wire logic                                   rvalid,
    input wire logic                                   rready,
    input wire logic                                   dutyWide16,
    input wire logic [NUM_SINK8-1:0][DUTY_BYTE_W-1:0]  sinkDuty8,
    input wire logic [NUM_SINK16-1:0][DUTY_WORD_W-1:0] sinkDuty16,
    input wire logic [DUTY_BYTE_W-1:0]                 sink5DutyHigh,
    input wire logic [DUTY_BYTE_W-1:0]                 sink12DutyLow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    // Write channel: answer next cycle, held, then gone
    write_resp_a: assert property (
        awvalid && awready && wvalid && wready |=> bvalid)
        else $error("write response missing");
    bresp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    bresp_done_a: assert property (
        bvalid && bready |=> !bvalid)
        else $error("write response lingers");
    write_block_a: assert property (
        bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");

    ////////////////////////////////////////////////////////////////////////
    // Read channel: answer two cycles after take, byte in lane zero
    read_lat_a: assert property (
        arvalid && arready |=> !rvalid ##1 rvalid)
        else $error("read answer latency wrong");
    rdata_hold_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed while stalled");
    read_block_a: assert property (
        rvalid |-> !arready)
        else $error("read taken while answer pending");
    byte_lane_a: assert property (
        rvalid |-> rdata[31:8] == 24'h0 &&
            (rresp != RESP_SLVERR || rdata == 32'h0))
        else $error("read data outside byte lane");

    ////////////////////////////////////////////////////////////////////////
    // Unused mode outputs stay zero once the width setting has settled
    narrow_mode_a: assert property (
        !dutyWide16 [*3] |-> sinkDuty16 == '0 &&
            sink5DutyHigh == 8'h00 && sink12DutyLow == 8'h00)
        else $error("wide outputs active in narrow mode");
    wide_mode_a: assert property (
        dutyWide16 [*3] |-> sinkDuty8 == '0)
        else $error("narrow outputs active in wide mode");
endmodule : ddrb_duty_bank_checker

bind ddrb_duty_bank ddrb_duty_bank_checker i_chk (
    .clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dutyWide16(dutyWide16), .sinkDuty8(sinkDuty8),
    .sinkDuty16(sinkDuty16), .sink5DutyHigh(sink5DutyHigh),
    .sink12DutyLow(sink12DutyLow)
);

// file: tb_ddrb_duty_bank.sv
// Self-checking bench for the duty byte bank
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_ddrb_duty_bank import ddrb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic                        clk, rst_b, awvalid, wvalid, bready;
    logic                        arvalid, rready, dutyWide16, awready;
    logic                        wready, bvalid, arready, rvalid;
    logic [AXI_ADDR_W-1:0]       awaddr, araddr;
    logic [2:0]                  awprot, arprot;
    logic [AXI_DATA_W-1:0]       wdata, rdata;
    logic [3:0]                  wstrb;
    logic [1:0]                  bresp, rresp;
    logic [NUM_SINK8-1:0][7:0]   sinkDuty8;
    logic [NUM_SINK16-1:0][15:0] sinkDuty16;
    logic [7:0]                  sink5DutyHigh, sink12DutyLow;
    int                          n_mismatch = 0;
    int                          n_checks = 0;

    ddrb_duty_bank i_dut (
        .clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .dutyWide16(dutyWide16),
        .sinkDuty8(sinkDuty8), .sinkDuty16(sinkDuty16),
        .sink5DutyHigh(sink5DutyHigh), .sink12DutyLow(sink12DutyLow));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte address of slot i (index 0x20b + i, four bytes per index)
    function automatic logic [11:0] adr(input int i);
        return 12'((32'h20b + i) * 4);
    endfunction : adr
    // Distinct non-zero pattern per slot, so swapped bytes show up
    function automatic logic [7:0] pat(input int i);
        return 8'(8'h3c + i * 8'h17);
    endfunction : pat

    // Write one byte; ready is judged at the negedge, stable until posedge
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic s, input logic [1:0] er);
        logic aw, w, b, ta, tw, tb;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b1;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= {3'h0, s};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (b) begin
            @(negedge clk);
            ta = aw & awready;
            tw = w & wready;
            tb = b & bvalid;
            if (tb) `CHK(bresp, er)
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            aw = aw & !ta;
            w = w & !tw;
            b = b & !tb;
        end
    endtask : wr

    // Read one byte and compare data and response
    task automatic rd(input logic [11:0] a, input logic [7:0] ed,
                      input logic [1:0] er);
        logic ar, r, ta, tr;
        ar = 1'b1;
        r = 1'b1;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (r) begin
            @(negedge clk);
            ta = ar & arready;
            tr = r & rvalid;
            if (tr) `CHK(rdata, {24'h0, ed})
            if (tr) `CHK(rresp, er)
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            ar = ar & !ta;
            r = r & !tr;
        end
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    // Reset for 5 cycles, then every byte and output must read zero
    task automatic t_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        `CHK({sinkDuty8, sinkDuty16, sink5DutyHigh, sink12DutyLow}, '0)
        for (int i = 0; i < 14; i++) rd(adr(i), 8'h00, RESP_OKAY);
    endtask : t_reset

    // Fill all bytes in narrow mode, read back, check per-sink duty
    task automatic t_fill();
        for (int i = 0; i < 14; i++) wr(adr(i), pat(i), 1'b1, RESP_OKAY);
        for (int i = 0; i < 14; i++) rd(adr(i), pat(i), RESP_OKAY);
        @(negedge clk);
        `CHK(sinkDuty8[0], pat(0))
        `CHK(sinkDuty8[1], pat(1))
        `CHK(sinkDuty8[2], pat(2))
        `CHK(sinkDuty8[3], pat(3))
        `CHK(sinkDuty8[4], pat(4))
        `CHK(sinkDuty8[5], pat(5))
        `CHK(sinkDuty8[6], pat(6))
        `CHK(sinkDuty16, '0)
    endtask : t_fill

    // Wide mode joins high over low; late write reaches the output
    task automatic t_wide();
        @(posedge clk);
        dutyWide16 <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK(sinkDuty16[0], {pat(2), pat(1)})
        `CHK(sinkDuty16[1], {pat(4), pat(3)})
        `CHK(sinkDuty16[2], {pat(6), pat(5)})
        `CHK(sinkDuty16[3], {pat(8), pat(7)})
        `CHK(sinkDuty16[4], {pat(10), pat(9)})
        `CHK(sinkDuty16[5], {pat(12), pat(11)})
        `CHK(sink5DutyHigh, pat(0))
        `CHK(sink12DutyLow, pat(13))
        `CHK(sinkDuty8, '0)
        wr(adr(13), 8'hc3, 1'b1, RESP_OKAY);
        @(negedge clk);
        `CHK(sink12DutyLow, 8'hc3)
    endtask : t_wide

    // Unmapped and misaligned places refuse; lane 0 strobe off keeps byte
    task automatic t_errors();
        logic [11:0] bad [3] = '{12'h828, 12'h864, 12'h82d};
        foreach (bad[j]) wr(bad[j], 8'hff, 1'b1, RESP_SLVERR);
        foreach (bad[j]) rd(bad[j], 8'h00, RESP_SLVERR);
        wr(adr(0), 8'hff, 1'b0, RESP_OKAY);
        rd(adr(0), pat(0), RESP_OKAY);
        rd(adr(12), pat(12), RESP_OKAY);
    endtask : t_errors

    // Late bready and rready: each answer must stand until it is taken;
    // upper write lanes carry junk that must never reach the byte
    task automatic t_stall();
        @(posedge clk);
        awaddr  <= adr(7);
        wdata   <= 32'ha5a5_a55a;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(posedge clk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({bvalid, bresp}, {1'b1, RESP_OKAY})
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        bready  <= 1'b0;
        araddr  <= adr(7);
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({rvalid, rresp}, {1'b1, RESP_OKAY})
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        `CHK(rdata, 32'h0000_005a)
        rready <= 1'b0;
        `CHK(sinkDuty16[3], {pat(8), 8'h5a})
    endtask : t_stall

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic finish_test();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    // Main sequence; reset is repeated as the last step with data stored
    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready, dutyWide16} = '0;
        {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
        t_reset();
        t_fill();
        t_wide();
        t_errors();
        t_stall();
        t_reset();
        finish_test();
    end
endmodule : tb_ddrb_duty_bank
